// file: core/sdi_defs.vh
// constants shared by the sdram interface device logic
`ifndef SDI_DEFS_VH
`define SDI_DEFS_VH

// command codes as {row strobe, column strobe, write enable}, all active low
`define SDI_CMD_MODE_WRITE 3'h0
`define SDI_CMD_REFRESH    3'h1
`define SDI_CMD_PRECHARGE  3'h2
`define SDI_CMD_ACTIVATE   3'h3
`define SDI_CMD_WRITE      3'h4
`define SDI_CMD_READ       3'h5
`define SDI_CMD_NOP        3'h7

// bank codes that pick the register written by a mode command
`define SDI_REG_MAIN       2'h0
`define SDI_REG_EXT1       2'h1
`define SDI_REG_EXT2       2'h2
`define SDI_REG_EXT3       2'h3

// address field positions
`define SDI_BIT_DLL_OFF    0
`define SDI_BIT_RTT_LO     2
`define SDI_BIT_RTT_HI     6
`define SDI_BIT_DLL_RESET  8
`define SDI_BIT_AUTO_PRE   10
`define SDI_BIT_COMP_OFF   10
`define SDI_BIT_A12        12
`define SDI_CAL_MSB        9
`define SDI_CAL_LSB        7
`define SDI_COL_MSB        9

// field values
`define SDI_CAL_DEFAULT    3'h7
`define SDI_CAL_EXIT       3'h0
`define SDI_BL_FOUR        3'h2
`define SDI_BL_EIGHT       3'h3
`define SDI_MIN_REFRESH    2'h2

// reset values of the mode registers
`define SDI_MAIN_RESET     13'h0002
`define SDI_EXT1_RESET     13'h0000

`endif

// file: core/sdi_fifo.v
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module sdi_fifo #(
   parameter WIDTH = 18,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clk_sys,
   input  wire             reset_n,
   input  wire [WIDTH-1:0] inData,
   input  wire             inValid,
   output wire             inReady,
   output wire [WIDTH-1:0] outData,
   output wire             outValid,
   input  wire             outReady
);
   reg  [WIDTH-1:0] mem [0:DEPTH-1];
   reg  [AW-1:0]    wrPtr;
   reg  [AW-1:0]    rdPtr;
   reg  [AW:0]      count;
   wire             push;
   wire             pop;

   // honest full and empty from the fill count
   assign inReady  = (count != DEPTH[AW:0]);
   assign outValid = (count != {(AW+1){1'b0}});
   assign outData  = mem[rdPtr];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // storage written at the write index
   always @(posedge clk_sys) begin
      if (push) begin
         mem[wrPtr] <= inData;
      end
   end

   // pointers and fill count
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wrPtr <= {AW{1'b0}};
         rdPtr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
         end
         if (push & ~pop) begin
            count <= count + 1'b1;
         end else if (pop & ~push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // sdi_fifo

// file: core/sdi_device.v
// sdram device side: command decode, init tracking, burst data lanes
`timescale 1ns/1ps
`include "sdi_defs.vh"
module sdi_device #(
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW    = 4
) (
   input  wire        clk_sys,
   input  wire        reset_n,
   input  wire        linkClock,
   input  wire        clockEnable,
   input  wire        chipSelect_n,
   input  wire        rowStrobe_n,
   input  wire        colStrobe_n,
   input  wire        writeEnable_n,
   input  wire [2:0]  bank_select,
   input  wire [12:0] address,
   input  wire        termination_enable,
   input  wire [15:0] dqIn,
   output reg  [15:0] dqOut,
   output reg         dqOe,
   input  wire        lower_byte_strobe_in,
   input  wire        upper_byte_strobe_in,
   output reg         byteStrobeOut,
   output wire        byteStrobeComplOut,
   output reg         byteStrobeOe,
   output wire        byteStrobeComplOe,
   input  wire        lower_write_mask,
   input  wire        upper_write_mask,
   output wire [15:0] wrData,
   output wire [1:0]  wrByteValid,
   output wire        wrValid,
   input  wire        wrReady,
   input  wire [15:0] rdData,
   output wire        rdReady,
   output reg         deviceReady,
   output reg         seqError,
   output reg         wrDropped,
   output wire        terminationOn,
   output wire        strobeComplEnable,
   output reg  [2:0]  openBank,
   output reg  [12:0] openRow,
   output reg  [9:0]  burstColumn,
   output reg         burstAutoPre,
   output reg         prechargePulse,
   output reg         prechargeAll,
   output reg  [2:0]  prechargeBank
);
   // -------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------
   localparam PW = 43;
   wire [PW-1:0] pinsRaw;
   reg  [PW-1:0] pinMeta;
   reg  [PW-1:0] pinSync;
   reg           ckPrev;
   reg  [1:0]    strobePrev;

   assign pinsRaw = {linkClock, clockEnable, chipSelect_n, rowStrobe_n, colStrobe_n, writeEnable_n,
                     bank_select, address, termination_enable, dqIn,
                     upper_byte_strobe_in, lower_byte_strobe_in, upper_write_mask, lower_write_mask};

   // two flops before any logic looks at a pin
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pinMeta    <= {PW{1'b0}};
         pinSync    <= {PW{1'b0}};
         ckPrev     <= 1'b0;
         strobePrev <= 2'h0;
      end else begin
         pinMeta    <= pinsRaw;
         pinSync    <= pinMeta;
         ckPrev     <= pinSync[42];
         strobePrev <= pinSync[3:2];
      end
   end

   wire        sCk     = pinSync[42];
   wire        sCke    = pinSync[41];
   wire        sCs_n   = pinSync[40];
   wire [2:0]  sCmd    = pinSync[39:37];
   wire [2:0]  sBank   = pinSync[36:34];
   wire [12:0] sAddr   = pinSync[33:21];
   wire        sTerm   = pinSync[20];
   wire [15:0] sDq     = pinSync[19:4];
   wire [1:0]  sStrobe = pinSync[3:2];
   wire [1:0]  sMask   = pinSync[1:0];
   wire        ckRise  = sCk & ~ckPrev;
   wire        ckFall  = ~sCk & ckPrev;
   wire [1:0]  strobeEdge = sStrobe ^ strobePrev;

   // command is taken at a clock rise with clock enable high and select low, nop otherwise
   wire        cmdTake = ckRise & sCke & ~sCs_n;
   wire [2:0]  cmd     = cmdTake ? sCmd : `SDI_CMD_NOP;
   wire        isModeWr = (cmd == `SDI_CMD_MODE_WRITE);
   wire [2:0]  calField = sAddr[`SDI_CAL_MSB:`SDI_CAL_LSB];

   // -------------------------------------------------------------
   // mode registers
   // -------------------------------------------------------------
   reg  [12:0] mainReg;
   reg  [12:0] ext1Reg;

   // main and ext-1 registers captured from the address lines
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mainReg <= `SDI_MAIN_RESET;
         ext1Reg <= `SDI_EXT1_RESET;
      end else if (isModeWr) begin
         if (sBank[1:0] == `SDI_REG_MAIN) begin
            mainReg <= sAddr;
         end else if (sBank[1:0] == `SDI_REG_EXT1) begin
            ext1Reg <= sAddr;
         end
      end
   end

   wire burstEight = (mainReg[2:0] == `SDI_BL_EIGHT);
   wire [3:0] burstBeats = burstEight ? 4'h8 : 4'h4;
   assign strobeComplEnable = ~ext1Reg[`SDI_BIT_COMP_OFF];
   assign terminationOn = sTerm & (ext1Reg[`SDI_BIT_RTT_LO] | ext1Reg[`SDI_BIT_RTT_HI]);

   // -------------------------------------------------------------
   // initialisation sequence tracker
   // -------------------------------------------------------------
   localparam [11:0] S_POWER  = 12'h001;
   localparam [11:0] S_PRE1   = 12'h002;
   localparam [11:0] S_EXT2   = 12'h004;
   localparam [11:0] S_EXT3   = 12'h008;
   localparam [11:0] S_EXT1   = 12'h010;
   localparam [11:0] S_DLLRST = 12'h020;
   localparam [11:0] S_PRE2   = 12'h040;
   localparam [11:0] S_REFR   = 12'h080;
   localparam [11:0] S_CALDEF = 12'h100;
   localparam [11:0] S_CALEX  = 12'h200;
   localparam [11:0] S_READY  = 12'h400;
   localparam [11:0] S_FAIL   = 12'h800;

   reg  [11:0] initState;
   reg  [11:0] next_initState;
   reg  [1:0]  refreshCount;
   wire        preAll = (cmd == `SDI_CMD_PRECHARGE) & sAddr[`SDI_BIT_AUTO_PRE];
   wire        isNop  = (cmd == `SDI_CMD_NOP);

   // each step before ready accepts only its own command or a nop; ready accepts any command
   always @* begin
      next_initState = initState;
      case (initState)
         S_POWER: begin
            if (!isNop) next_initState = S_FAIL;
            else if (sCke) next_initState = S_PRE1;
         end
         S_PRE1: begin
            if (preAll) next_initState = S_EXT2;
            else if (!isNop) next_initState = S_FAIL;
         end
         S_EXT2: begin
            if (isModeWr && sBank[1:0] == `SDI_REG_EXT2) next_initState = S_EXT3;
            else if (!isNop) next_initState = S_FAIL;
         end
         S_EXT3: begin
            if (isModeWr && sBank[1:0] == `SDI_REG_EXT3) next_initState = S_EXT1;
            else if (!isNop) next_initState = S_FAIL;
         end
         S_EXT1: begin
            if (isModeWr && sBank[1:0] == `SDI_REG_EXT1 && !sAddr[`SDI_BIT_DLL_OFF] && !sAddr[`SDI_BIT_A12])
               next_initState = S_DLLRST;
            else if (!isNop) next_initState = S_FAIL;
         end
         S_DLLRST: begin
            if (isModeWr && sBank[1:0] == `SDI_REG_MAIN && sAddr[`SDI_BIT_DLL_RESET]) next_initState = S_PRE2;
            else if (!isNop) next_initState = S_FAIL;
         end
         S_PRE2: begin
            if (preAll) next_initState = S_REFR;
            else if (!isNop) next_initState = S_FAIL;
         end
         S_REFR: begin
            if (cmd == `SDI_CMD_REFRESH) next_initState = S_REFR;
            else if (isModeWr && sBank[1:0] == `SDI_REG_MAIN && !sAddr[`SDI_BIT_DLL_RESET] &&
                     refreshCount == `SDI_MIN_REFRESH) next_initState = S_CALDEF;
            else if (!isNop) next_initState = S_FAIL;
         end
         S_CALDEF: begin
            if (isModeWr && sBank[1:0] == `SDI_REG_EXT1 && calField == `SDI_CAL_DEFAULT) next_initState = S_CALEX;
            else if (!isNop) next_initState = S_FAIL;
         end
         S_CALEX: begin
            if (isModeWr && sBank[1:0] == `SDI_REG_EXT1 && calField == `SDI_CAL_EXIT) next_initState = S_READY;
            else if (!isNop) next_initState = S_FAIL;
         end
         S_READY: next_initState = S_READY;
         default: next_initState = S_FAIL;
      endcase
   end

   // sequence state, refresh count and status flags
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         initState    <= S_POWER;
         refreshCount <= 2'h0;
         deviceReady  <= 1'b0;
         seqError     <= 1'b0;
      end else begin
         initState <= next_initState;
         if (initState == S_REFR && cmd == `SDI_CMD_REFRESH && refreshCount != `SDI_MIN_REFRESH) begin
            refreshCount <= refreshCount + 1'b1;
         end
         deviceReady <= (next_initState == S_READY);
         seqError    <= (next_initState == S_FAIL);
      end
   end

   // -------------------------------------------------------------
   // row, column and precharge bookkeeping
   // -------------------------------------------------------------
   wire accWrite = deviceReady & (cmd == `SDI_CMD_WRITE);
   wire accRead  = deviceReady & (cmd == `SDI_CMD_READ);
   reg  writeActive;
   reg  readActive;
   reg  [3:0] beatsLeft;
   wire burstDone;

   // activate opens a row, access latches column and auto-precharge
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         openBank       <= 3'h0;
         openRow        <= 13'h0000;
         burstColumn    <= 10'h000;
         burstAutoPre   <= 1'b0;
         prechargePulse <= 1'b0;
         prechargeAll   <= 1'b0;
         prechargeBank  <= 3'h0;
      end else begin
         prechargePulse <= 1'b0;
         if (deviceReady && cmd == `SDI_CMD_ACTIVATE) begin
            openBank <= sBank;
            openRow  <= sAddr;
         end
         if (accWrite | accRead) begin
            burstColumn  <= sAddr[`SDI_COL_MSB:0];
            burstAutoPre <= sAddr[`SDI_BIT_AUTO_PRE];
         end
         if (cmd == `SDI_CMD_PRECHARGE) begin
            prechargePulse <= 1'b1;
            prechargeAll   <= sAddr[`SDI_BIT_AUTO_PRE];
            prechargeBank  <= sBank;
         end else if (burstDone && burstAutoPre) begin
            prechargePulse <= 1'b1;
            prechargeAll   <= 1'b0;
            prechargeBank  <= openBank;
         end
      end
   end

   // -------------------------------------------------------------
   // write lanes into the fifo
   // -------------------------------------------------------------
   reg  [7:0] laneData [0:1];
   reg  [1:0] laneKeep;
   reg  [1:0] laneGot;
   wire       beatDone = writeActive & (laneGot == 2'h3);
   wire       fifoInReady;
   wire [17:0] fifoIn = {laneKeep, laneData[1], laneData[0]};
   wire       beatUseful = beatDone & (laneKeep != 2'h0);
   wire       readBeat = readActive & (ckRise | ckFall);
   assign burstDone = (beatDone | readBeat) & (beatsLeft == 4'h1);

   // each lane latches its byte and mask on either edge of its own strobe
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         laneData[0] <= 8'h00;
         laneData[1] <= 8'h00;
         laneKeep    <= 2'h0;
         laneGot     <= 2'h0;
         wrDropped   <= 1'b0;
      end else begin
         if (beatDone) begin
            laneGot <= 2'h0;
         end
         if (writeActive && strobeEdge[0] && (!laneGot[0] || beatDone)) begin
            laneData[0] <= sDq[7:0];
            laneKeep[0] <= ~sMask[0];
            laneGot[0]  <= 1'b1;
         end
         if (writeActive && strobeEdge[1] && (!laneGot[1] || beatDone)) begin
            laneData[1] <= sDq[15:8];
            laneKeep[1] <= ~sMask[1];
            laneGot[1]  <= 1'b1;
         end
         if (beatUseful && !fifoInReady) begin
            wrDropped <= 1'b1;
         end
      end
   end

   sdi_fifo #(
      .WIDTH (18),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clk_sys  (clk_sys),
      .reset_n  (reset_n),
      .inData   (fifoIn),
      .inValid  (beatUseful),
      .inReady  (fifoInReady),
      .outData  ({wrByteValid, wrData}),
      .outValid (wrValid),
      .outReady (wrReady)
   );

   // -------------------------------------------------------------
   // burst control and read drive
   // -------------------------------------------------------------
   assign rdReady           = readBeat;
   assign byteStrobeComplOut = ~byteStrobeOut;
   assign byteStrobeComplOe  = byteStrobeOe & strobeComplEnable;

   // burst counts beats; read data and strobe change on the same clock edge
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         writeActive   <= 1'b0;
         readActive    <= 1'b0;
         beatsLeft     <= 4'h0;
         dqOut         <= 16'h0000;
         dqOe          <= 1'b0;
         byteStrobeOut <= 1'b0;
         byteStrobeOe  <= 1'b0;
      end else begin
         if (accWrite) begin
            writeActive <= 1'b1;
            readActive  <= 1'b0;
            beatsLeft   <= burstBeats;
         end else if (accRead) begin
            readActive    <= 1'b1;
            writeActive   <= 1'b0;
            beatsLeft     <= burstBeats;
            byteStrobeOut <= 1'b0;
            byteStrobeOe  <= 1'b1;
            dqOe          <= 1'b1;
         end else if (beatDone | readBeat) begin
            beatsLeft <= beatsLeft - 1'b1;
            if (readBeat) begin
               dqOut         <= rdData;
               byteStrobeOut <= ~byteStrobeOut;
            end
            if (beatsLeft == 4'h1) begin
               writeActive <= 1'b0;
               readActive  <= 1'b0;
            end
         end else if (!readActive && ckRise) begin
            dqOe         <= 1'b0;
            byteStrobeOe <= 1'b0;
         end
      end
   end
endmodule // sdi_device

// file: dv/sdi_device_monitor.sv
// assertions and cover points on the ports of the sdram device block
`timescale 1ns/1ps
module sdi_device_monitor (
   input wire        clk_sys,
   input wire        reset_n,
   input wire        termination_enable,
   input wire [15:0] rdData,
   input wire        rdReady,
   input wire [15:0] dqOut,
   input wire        dqOe,
   input wire        byteStrobeOut,
   input wire        byteStrobeComplOut,
   input wire        byteStrobeOe,
   input wire        byteStrobeComplOe,
   input wire        strobeComplEnable,
   input wire        terminationOn,
   input wire        wrValid,
   input wire [1:0]  wrByteValid,
   input wire        wrDropped,
   input wire        deviceReady,
   input wire        seqError,
   input wire        prechargePulse,
   input wire        prechargeAll
);
   // all checks run on the system clock and sleep during reset
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // -----------------------------------------
   // read lanes and strobes
   // -----------------------------------------
   chk_read_data: assert property (rdReady |=> dqOut == $past(rdData))
      else $error("read beat not launched on the data pins");
   chk_strobe_edge: assert property (rdReady |=> byteStrobeOut != $past(byteStrobeOut))
      else $error("read strobe did not move with the beat");
   chk_read_drive: assert property (rdReady |-> dqOe && byteStrobeOe)
      else $error("read beat while pins not driven");
   chk_compl_strobe: assert property (byteStrobeComplOut == !byteStrobeOut
      && byteStrobeComplOe == (byteStrobeOe && strobeComplEnable))
      else $error("complement strobe not following its enable");
   // -----------------------------------------
   // write path, termination and sequence state
   // -----------------------------------------
   chk_term_ignore: assert property (!termination_enable [*4] |-> !terminationOn)
      else $error("termination on with its pin low");
   chk_mask_drop: assert property (wrValid |-> wrByteValid != 2'h0)
      else $error("fully masked beat reached the buffer");
   chk_access_gate: assert property (!deviceReady |-> !wrValid && !dqOe)
      else $error("data traffic before initialisation finished");
   chk_error_hold: assert property (seqError |=> seqError)
      else $error("sequence error flag released");
   chk_ready_hold: assert property (deviceReady |=> deviceReady)
      else $error("ready flag dropped");
   chk_pre_pulse: assert property (prechargePulse |=> !prechargePulse)
      else $error("precharge pulse longer than one cycle");
   // main scenarios reached
   cover property ($rose(deviceReady));
   cover property (rdReady);
   cover property (prechargePulse && prechargeAll);
   cover property ($rose(wrDropped));
endmodule // sdi_device_monitor

bind sdi_device sdi_device_monitor sdi_device_monitor_inst (
   .clk_sys, .reset_n, .termination_enable, .rdData, .rdReady, .dqOut, .dqOe, .byteStrobeOut,
   .byteStrobeComplOut, .byteStrobeOe, .byteStrobeComplOe, .strobeComplEnable, .terminationOn,
   .wrValid, .wrByteValid, .wrDropped, .deviceReady, .seqError, .prechargePulse, .prechargeAll
);

// file: dv/sdi_ctrl_model.sv
// controller-side model: memory clock, command pins and write beats
`timescale 1ns/1ps
`include "sdi_defs.vh"
module sdi_ctrl_model (
   input  wire        clk_sys,
   input  wire        rdReady,
   output reg         linkClock,
   output reg         clockEnable,
   output reg         chipSelect_n,
   output reg  [2:0]  cmdCode,
   output reg  [2:0]  bank_select,
   output reg  [12:0] address,
   output reg  [15:0] dqDrive,
   output reg         lowerStrobe,
   output reg         upperStrobe,
   output reg         lower_write_mask,
   output reg         upper_write_mask,
   output reg  [15:0] rdData
);
   // free-running memory clock, phase offset from the system clock
   initial begin
      linkClock = 1'b0;
      #7;
      forever #200 linkClock = ~linkClock;
   end
   // power-up levels: clock enable low, bus deselected
   initial begin
      clockEnable = 1'b0;
      chipSelect_n = 1'b1;
      cmdCode = `SDI_CMD_NOP;
      bank_select = 3'h0;
      address = 13'h0000;
      dqDrive = 16'h0000;
      {lowerStrobe, upperStrobe, lower_write_mask, upper_write_mask} = 4'h0;
      rdData = 16'h1234;
   end
   // read beats: a new word after each one the device takes
   always @(posedge clk_sys) begin
      if (rdReady) rdData <= rdData + 16'h1111;
   end
   // one command held across one memory clock rise, then the bus released
   task cmd(input [2:0] c, input [2:0] ba, input [12:0] a);
      begin
         @(negedge linkClock);
         @(posedge clk_sys);
         chipSelect_n <= 1'b0;
         cmdCode <= c;
         bank_select <= ba;
         address <= a;
         @(negedge linkClock);
         @(posedge clk_sys);
         chipSelect_n <= 1'b1;
         cmdCode <= `SDI_CMD_NOP;
         address <= ~a;
      end
   endtask
   // idle wait with clock enable low, then raise it
   task powerUp;
      begin
         @(posedge clk_sys) clockEnable <= 1'b0;
         repeat (500) @(posedge linkClock);
         @(posedge clk_sys) clockEnable <= 1'b1;
      end
   endtask
   // full start-up sequence, only the prescribed commands in order
   task init(input [12:0] e1);
      begin
         powerUp;
         repeat (2) @(posedge linkClock);
         cmd(`SDI_CMD_PRECHARGE, 3'h0, 13'h0400);
         cmd(`SDI_CMD_MODE_WRITE, 3'h2, 13'h0000);
         cmd(`SDI_CMD_MODE_WRITE, 3'h3, 13'h0000);
         cmd(`SDI_CMD_MODE_WRITE, 3'h1, e1 & 13'h0FFE);
         cmd(`SDI_CMD_MODE_WRITE, 3'h0, 13'h0100);
         cmd(`SDI_CMD_PRECHARGE, 3'h0, 13'h0400);
         cmd(`SDI_CMD_REFRESH, 3'h0, 13'h0000);
         cmd(`SDI_CMD_REFRESH, 3'h0, 13'h0000);
         cmd(`SDI_CMD_MODE_WRITE, 3'h0, 13'h0003);
         repeat (200) @(posedge linkClock);
         cmd(`SDI_CMD_MODE_WRITE, 3'h1, e1 | 13'h0380);
         cmd(`SDI_CMD_MODE_WRITE, 3'h1, e1);
      end
   endtask
   // eight write beats; beat 1 masks the low byte, beat 2 both bytes
   task beats(input [3:0] b);
      integer i;
      begin
         for (i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            dqDrive <= {8'hA0, b, i[3:0]};
            lower_write_mask <= (i == 1 || i == 2);
            upper_write_mask <= (i == 2);
            repeat (3) @(posedge clk_sys);
            lowerStrobe <= ~lowerStrobe; // strobe edge mid-eye
            upperStrobe <= ~upperStrobe;
            repeat (3) @(posedge clk_sys);
         end
         dqDrive <= ~dqDrive;
      end
   endtask
endmodule // sdi_ctrl_model

// file: dv/tb.sv
// self-checking bench for the sdram device block
`timescale 1ns/1ps
`include "sdi_defs.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module tb;
   reg         clk_sys = 1'b0;
   reg         reset_n = 1'b0;
   reg         wrReady = 1'b0;
   reg         termPin = 1'b0;
   reg  [3:0]  lastPre = 4'h0;
   integer     rdCount = 0;
   integer     n_fail = 0;
   integer     n_checks = 0;
   wire [15:0] dqIn, dqOut, dqDrive, wrData, rdData;
   wire [12:0] address, openRow;
   wire [9:0]  burstColumn;
   wire [2:0]  cmdCode, bank_select, openBank, prechargeBank;
   wire [1:0]  wrByteValid;
   wire        linkClock, clockEnable, chipSelect_n, lowerStrobe, upperStrobe, lower_write_mask, upper_write_mask;
   wire        dqOe, byteStrobeOut, byteStrobeOe, wrValid, rdReady, deviceReady, seqError, wrDropped;
   wire        terminationOn, strobeComplEnable, burstAutoPre, prechargePulse, prechargeAll;
   // clock, shared data wires, precharge and read beat logging
   always #25 clk_sys = ~clk_sys;
   assign dqIn = dqOe ? dqOut : dqDrive;
   always @(posedge clk_sys) begin
      if (prechargePulse) lastPre <= {prechargeAll, prechargeBank};
      if (rdReady) rdCount <= rdCount + 1;
   end
   sdi_device #(.FIFO_DEPTH(16), .FIFO_AW(4)) sdi_device_inst (
      .clk_sys, .reset_n, .linkClock, .clockEnable, .chipSelect_n, .rowStrobe_n(cmdCode[2]),
      .colStrobe_n(cmdCode[1]), .writeEnable_n(cmdCode[0]), .bank_select, .address, .termination_enable(termPin),
      .dqIn, .dqOut, .dqOe, .lower_byte_strobe_in(byteStrobeOe ? byteStrobeOut : lowerStrobe),
      .upper_byte_strobe_in(byteStrobeOe ? byteStrobeOut : upperStrobe), .byteStrobeOut,
      .byteStrobeComplOut(), .byteStrobeOe, .byteStrobeComplOe(), .lower_write_mask, .upper_write_mask,
      .wrData, .wrByteValid, .wrValid, .wrReady, .rdData, .rdReady, .deviceReady, .seqError, .wrDropped,
      .terminationOn, .strobeComplEnable, .openBank, .openRow, .burstColumn, .burstAutoPre, .prechargePulse,
      .prechargeAll, .prechargeBank);
   sdi_ctrl_model m (
      .clk_sys, .rdReady, .linkClock, .clockEnable, .chipSelect_n, .cmdCode, .bank_select, .address,
      .dqDrive, .lowerStrobe, .upperStrobe, .lower_write_mask, .upper_write_mask, .rdData);
   // -----------------------------------------
   // scenarios
   // -----------------------------------------
   // termination ignored while off, out-of-order command, mid-run reset
   task t_refuse;
      begin
         @(posedge clk_sys) termPin <= 1'b1;
         m.powerUp;
         `CHK(terminationOn, 1'b0)
         m.cmd(`SDI_CMD_MODE_WRITE, 3'h0, 13'h0100);
         repeat (6) @(posedge clk_sys);
         `CHK(seqError, 1'b1)
         `CHK(deviceReady, 1'b0)
         termPin <= 1'b0;
         reset_n <= 1'b0;
         repeat (4) @(posedge clk_sys);
         reset_n <= 1'b1;
         @(posedge clk_sys);
         `CHK(seqError, 1'b0)
      end
   endtask
   // full start-up with termination enabled in extended register 1
   task t_init;
      begin
         m.init(13'h0004);
         repeat (6) @(posedge clk_sys);
         `CHK(deviceReady, 1'b1)
         `CHK(seqError, 1'b0)
         `CHK(strobeComplEnable, 1'b1)
         m.cmd(`SDI_CMD_MODE_WRITE, 3'h1, 13'h0404);
         `CHK(strobeComplEnable, 1'b0)
         m.cmd(`SDI_CMD_MODE_WRITE, 3'h1, 13'h0004);
         termPin <= 1'b1;
         repeat (6) @(posedge clk_sys);
         `CHK(terminationOn, 1'b1)
         termPin <= 1'b0;
      end
   endtask
   // activate, three masked write bursts into a stalled buffer, then drain
   task t_write;
      integer b, i, k;
      reg [15:0] expD [0:15];
      reg [1:0]  expV [0:15];
      begin
         k = 0;
         for (b = 0; b < 3; b++) for (i = 0; i < 8; i++) if (i != 2 && k < 16) begin
            expV[k] = (i == 1) ? 2'h2 : 2'h3;
            expD[k] = {8'hA0, b[3:0], i[3:0]} & ((i == 1) ? 16'hFF00 : 16'hFFFF);
            k++;
         end
         m.cmd(`SDI_CMD_ACTIVATE, 3'h5, 13'h1ABC);
         repeat (4) @(posedge clk_sys);
         `CHK(openBank, 3'h5)
         `CHK(openRow, 13'h1ABC)
         for (b = 0; b < 3; b++) begin
            m.cmd(`SDI_CMD_WRITE, 3'h5, (b == 2) ? 13'h06A5 : 13'h02A5);
            m.beats(b[3:0]);
         end
         repeat (8) @(posedge clk_sys);
         `CHK(burstColumn, 10'h2A5)
         `CHK(burstAutoPre, 1'b1)
         `CHK(lastPre, 4'h5)
         `CHK(wrDropped, 1'b1)
         wrReady <= 1'b1;
         k = 0;
         repeat (40) begin
            @(posedge clk_sys);
            if (wrValid === 1'b1 && k < 16) begin
               `CHK(wrData & {{8{expV[k][1]}}, {8{expV[k][0]}}}, expD[k])
               `CHK(wrByteValid, expV[k])
               k++;
            end
         end
         wrReady <= 1'b0;
         `CHK(k, 16)
         `CHK(wrValid, 1'b0)
      end
   endtask
   // eight-beat read, then single-bank and all-bank precharge
   task t_read;
      begin
         m.cmd(`SDI_CMD_ACTIVATE, 3'h5, 13'h0001);
         rdCount <= 0;
         m.cmd(`SDI_CMD_READ, 3'h5, 13'h0010);
         repeat (80) @(posedge clk_sys);
         `CHK(rdCount, 8)
         `CHK(dqOe, 1'b0)
         m.cmd(`SDI_CMD_PRECHARGE, 3'h3, 13'h0000);
         repeat (6) @(posedge clk_sys);
         `CHK(lastPre, 4'h3)
         m.cmd(`SDI_CMD_PRECHARGE, 3'h2, 13'h0400);
         repeat (6) @(posedge clk_sys);
         `CHK(lastPre[3], 1'b1)
      end
   endtask
   // verdict and end of run
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", n_checks, n_fail);
         if (n_fail == 0 && n_checks > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   // main sequence
   initial begin
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      t_refuse;
      t_init;
      t_write;
      t_read;
      complete_run;
   end
   // watchdog well beyond the expected run time
   initial begin
      #3000000;
      n_fail++;
      complete_run;
   end
endmodule // tb
